/* design/partner_ability_cfg.svh */
// Offsets, field positions and fixed values of the emulated partner ability word.
`ifndef PARTNER_ABILITY_CFG_SVH
`define PARTNER_ABILITY_CFG_SVH

`define LPA_BYTE_OFFSET   12'h01d4
`define LPA_INDEX         5'h05
`define LPA_ADDR_W        12
`define LPA_DATA_W        32
`define LPA_SER_W         16

`define LPA_NEXT_PAGE_BIT 15
`define LPA_ACK_BIT       14
`define LPA_RFAULT_BIT    13
`define LPA_RSVD12_BIT    12
`define LPA_ASYM_BIT      11
`define LPA_SYM_BIT       10
`define LPA_T4_BIT        9
`define LPA_SPD_HI        8
`define LPA_SPD_LO        5
`define LPA_SEL_HI        4
`define LPA_SEL_LO        0

`define ADV_ASYM_BIT      11
`define ADV_SYM_BIT       10

`define LPA_NEXT_PAGE_VAL 1'b0
`define LPA_ACK_VAL       1'b1
`define LPA_RFAULT_VAL    1'b0
`define LPA_T4_VAL        1'b0
`define LPA_SEL_IEEE      5'h01

`define LPA_SPD_10_FULL   4'h2
`define LPA_SPD_100_FULL  4'h8
`define LPA_SPD_10_HALF   4'h1
`define LPA_SPD_100_HALF  4'h4
`define LPA_SPD_NONE      4'h0

`define LPA_ZERO32        32'h0000_0000

`endif

/* design/partner_ability_pkg.sv */
// Types shared by the emulated partner ability logic.
package partner_ability_pkg;

  typedef struct packed {
    logic        en;
    logic        serial;
    logic [11:0] addr;
  } rd_req_type;

  typedef struct packed {
    logic        en;
    logic        serial;
    logic [11:0] addr;
    logic [31:0] data;
  } wr_req_type;

  typedef struct packed {
    logic speed;
    logic duplex_pol;
  } strap_type;

endpackage

/* design/partner_ability.sv */
// Emulated link partner base page ability word with its register read port.
`timescale 1ns/1ns
`include "partner_ability_cfg.svh"

module partner_ability
  import partner_ability_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire rd_req_type  rd_req,
  input  wire wr_req_type  wr_req,
  input  wire logic [15:0] vphy_advert_reg,
  input  wire logic        an_fail,
  input  wire logic        duplex_pin,
  input  wire logic        speed_strap_pin,
  input  wire logic        duplex_pol_strap_pin,
  output logic [31:0]      rd_data_q,
  output logic             rd_valid_q
);

  // Returns true when a read or write request addresses the ability word.
  function automatic logic addr_hit(input logic serial, input logic [11:0] addr);
    if (serial) begin
      addr_hit = (addr == {7'h00, `LPA_INDEX});
    end else begin
      addr_hit = (addr == `LPA_BYTE_OFFSET);
    end
  endfunction

  // Two-stage synchronisers for the pins; the first stage feeds only the second.
  logic      duplex_meta_q;
  logic      duplex_sync_q;
  strap_type strap_meta_q;
  strap_type strap_sync_q;

  always_ff @(posedge clk) begin
    duplex_meta_q <= duplex_pin;
    duplex_sync_q <= duplex_meta_q;
    strap_meta_q  <= '{speed: speed_strap_pin, duplex_pol: duplex_pol_strap_pin};
    strap_sync_q  <= strap_meta_q;
  end

  // Strap capture on the first edge after reset release.
  logic      rst_seen_q;
  logic      rst_seen_d;
  strap_type strap_q;
  strap_type strap_d;

  always_comb begin
    rst_seen_d = 1'b0;
    strap_d    = strap_q;
    if (rst_seen_q) begin
      strap_d = strap_sync_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rst_seen_q <= 1'b1;
      strap_q    <= '{speed: 1'b0, duplex_pol: 1'b0};
    end else begin
      rst_seen_q <= rst_seen_d;
      strap_q    <= strap_d;
    end
  end

  // The ability word is rebuilt every cycle from present inputs, the synchronised duplex pin and the latched straps.
  logic [31:0] word;
  logic        adv_sym;
  logic        adv_asym;
  logic [3:0]  speed_bits;

  always_comb begin
    adv_sym  = vphy_advert_reg[`ADV_SYM_BIT];
    adv_asym = vphy_advert_reg[`ADV_ASYM_BIT];
    if (an_fail) begin
      speed_bits = `LPA_SPD_NONE;
    end else if (duplex_sync_q == strap_q.duplex_pol) begin
      speed_bits = strap_q.speed ? `LPA_SPD_100_FULL : `LPA_SPD_10_FULL;
    end else begin
      speed_bits = strap_q.speed ? `LPA_SPD_100_HALF : `LPA_SPD_10_HALF;
    end
    word                                = `LPA_ZERO32;
    word[`LPA_NEXT_PAGE_BIT]            = `LPA_NEXT_PAGE_VAL;
    word[`LPA_ACK_BIT]                  = `LPA_ACK_VAL;
    word[`LPA_RFAULT_BIT]               = `LPA_RFAULT_VAL;
    word[`LPA_SYM_BIT]                  = adv_sym ^ adv_asym;
    word[`LPA_ASYM_BIT]                 = adv_asym;
    word[`LPA_T4_BIT]                   = `LPA_T4_VAL;
    word[`LPA_SPD_HI:`LPA_SPD_LO]       = speed_bits;
    word[`LPA_SEL_HI:`LPA_SEL_LO]       = `LPA_SEL_IEEE;
  end

  // Read port: data one cycle after the request; unmapped reads return zero.
  // Write requests are accepted and dropped, so they never alter the word.
  logic [31:0] rd_data_d;
  logic        rd_valid_d;

  always_comb begin
    rd_valid_d = rd_req.en;
    rd_data_d  = `LPA_ZERO32;
    if (rd_req.en && addr_hit(rd_req.serial, rd_req.addr)) begin
      rd_data_d = rd_req.serial ? {16'h0000, word[15:0]} : word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_q  <= `LPA_ZERO32;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // Checks on the read answer and strap holding.
  sequence hit_read_s;
    rd_req.en && addr_hit(rd_req.serial, rd_req.addr) ##1 rd_valid_q;
  endsequence

  sequence hit_write_read_s;
    wr_req.en && addr_hit(wr_req.serial, wr_req.addr) && rd_req.en
      && addr_hit(rd_req.serial, rd_req.addr) ##1 rd_valid_q;
  endsequence

  // Named steps of a read: the request with its conditions, then the answer.
  sequence good_read_s;
    rd_req.en && addr_hit(rd_req.serial, rd_req.addr) && !an_fail ##1 rd_valid_q;
  endsequence

  sequence failed_read_s;
    rd_req.en && addr_hit(rd_req.serial, rd_req.addr) && an_fail ##1 rd_valid_q;
  endsequence

  sequence half_read_s;
    rd_req.en && addr_hit(rd_req.serial, rd_req.addr) && !an_fail
      && duplex_sync_q != strap_q.duplex_pol ##1 rd_valid_q;
  endsequence

  sequence miss_read_s;
    rd_req.en && !addr_hit(rd_req.serial, rd_req.addr) ##1 rd_valid_q;
  endsequence

  next_page_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_read_s |-> !rd_data_q[`LPA_NEXT_PAGE_BIT])
    else $error("Next page bit read as one.");

  ack_one_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_read_s |-> rd_data_q[`LPA_ACK_BIT])
    else $error("Acknowledge bit read as zero.");

  remote_fault_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_read_s |-> !rd_data_q[`LPA_RFAULT_BIT])
    else $error("Remote fault bit read as one.");

  t4_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_read_s |-> !rd_data_q[`LPA_T4_BIT])
    else $error("100BASE-T4 bit read as one.");

  selector_code_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_read_s |-> rd_data_q[`LPA_SEL_HI:`LPA_SEL_LO] == `LPA_SEL_IEEE)
    else $error("Selector field is not the IEEE code.");

  pause_map_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_read_s |->
      rd_data_q[`LPA_ASYM_BIT] == $past(vphy_advert_reg[`ADV_ASYM_BIT])
      && rd_data_q[`LPA_SYM_BIT] == ($past(vphy_advert_reg[`ADV_SYM_BIT])
                                    != $past(vphy_advert_reg[`ADV_ASYM_BIT])))
    else $error("Partner pause bits do not follow the advertisement.");

  speed_map_a: assert property (
    @(posedge clk) disable iff (rst)
    good_read_s |->
      rd_data_q[`LPA_SPD_HI:`LPA_SPD_LO] ==
        (($past(duplex_sync_q) == strap_q.duplex_pol)
          ? (strap_q.speed ? `LPA_SPD_100_FULL : `LPA_SPD_10_FULL)
          : (strap_q.speed ? `LPA_SPD_100_HALF : `LPA_SPD_10_HALF)))
    else $error("Speed and duplex bits disagree with pin and straps.");

  an_fail_speed_a: assert property (
    @(posedge clk) disable iff (rst)
    failed_read_s |->
      rd_data_q[`LPA_SPD_HI:`LPA_SPD_LO] == `LPA_SPD_NONE)
    else $error("Ability bits set although negotiation failed.");

  strap_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) && !$past(rst_seen_q) |-> $stable(strap_q))
    else $error("Latched straps changed after reset release.");

  strap_capture_a: assert property (
    @(posedge clk) disable iff (rst)
    rst_seen_q |=> strap_q == $past(strap_sync_q))
    else $error("Straps not captured at reset release.");

  upper_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    rd_valid_q |-> rd_data_q[31:16] == 16'h0000 && !rd_data_q[`LPA_RSVD12_BIT])
    else $error("Reserved bits read as nonzero.");

  write_ignored_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_write_read_s |-> rd_data_q[`LPA_ACK_BIT] && !rd_data_q[`LPA_NEXT_PAGE_BIT]
      && rd_data_q[`LPA_SEL_HI:`LPA_SEL_LO] == `LPA_SEL_IEEE)
    else $error("A write altered the ability word.");

  // Each row of the pause grant table, checked on its own.
  pause_none_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_read_s |-> $past(vphy_advert_reg[`ADV_ASYM_BIT:`ADV_SYM_BIT]) != 2'h0
      || (!rd_data_q[`LPA_SYM_BIT] && !rd_data_q[`LPA_ASYM_BIT]))
    else $error("Partner offers pause although none was asked.");

  pause_sym_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_read_s |-> $past(vphy_advert_reg[`ADV_ASYM_BIT:`ADV_SYM_BIT]) != 2'h1
      || (rd_data_q[`LPA_SYM_BIT] && !rd_data_q[`LPA_ASYM_BIT]))
    else $error("Partner does not grant symmetric pause.");

  pause_asym_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_read_s |-> $past(vphy_advert_reg[`ADV_ASYM_BIT:`ADV_SYM_BIT]) != 2'h2
      || (rd_data_q[`LPA_SYM_BIT] && rd_data_q[`LPA_ASYM_BIT]))
    else $error("Partner does not grant pause towards the switch.");

  pause_both_a: assert property (
    @(posedge clk) disable iff (rst)
    hit_read_s |-> $past(vphy_advert_reg[`ADV_ASYM_BIT:`ADV_SYM_BIT]) != 2'h3
      || (!rd_data_q[`LPA_SYM_BIT] && rd_data_q[`LPA_ASYM_BIT]))
    else $error("Partner does not grant pause towards the MAC.");

  // Read handshake, reset and synchroniser checks.
  reset_quiet_a: assert property (
    @(posedge clk)
    rst |=> !rd_valid_q && rd_data_q == `LPA_ZERO32)
    else $error("Read port not quiet during reset.");

  valid_pulse_a: assert property (
    @(posedge clk) disable iff (rst)
    rd_req.en |=> rd_valid_q)
    else $error("Read request got no answer.");

  valid_idle_a: assert property (
    @(posedge clk) disable iff (rst)
    !rd_req.en |=> !rd_valid_q && rd_data_q == `LPA_ZERO32)
    else $error("Read answer without a request.");

  write_silent_a: assert property (
    @(posedge clk) disable iff (rst)
    wr_req.en && !rd_req.en |=> !rd_valid_q)
    else $error("A write produced a read answer.");

  miss_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    miss_read_s |-> rd_data_q == `LPA_ZERO32)
    else $error("Unmapped read returned data.");

  serial_upper_a: assert property (
    @(posedge clk) disable iff (rst)
    rd_req.en && rd_req.serial |=> rd_data_q[31:16] == 16'h0000)
    else $error("Serial read returned bits above the low half.");

  half_duplex_a: assert property (
    @(posedge clk) disable iff (rst)
    half_read_s |-> rd_data_q[`LPA_SPD_HI:`LPA_SPD_LO]
      == (strap_q.speed ? `LPA_SPD_100_HALF : `LPA_SPD_10_HALF))
    else $error("Half duplex ability bits wrong for a duplex mismatch.");

  fail_keeps_a: assert property (
    @(posedge clk) disable iff (rst)
    failed_read_s |-> rd_data_q[`LPA_ACK_BIT]
      && rd_data_q[`LPA_SEL_HI:`LPA_SEL_LO] == `LPA_SEL_IEEE)
    else $error("Fixed bits lost when negotiation failed.");

  strap_pins_a: assert property (
    @(posedge clk) disable iff (rst)
    $fell(rst) |=> strap_q.speed == $past(speed_strap_pin, 3)
      && strap_q.duplex_pol == $past(duplex_pol_strap_pin, 3))
    else $error("Latched straps differ from the pins at reset release.");

  duplex_sync_a: assert property (
    @(posedge clk) disable iff (rst)
    duplex_sync_q == $past(duplex_pin, 2))
    else $error("Duplex pin synchroniser lost a sample.");

endmodule // partner_ability

/* dv/mgmt_host.sv */
// Management host model that issues register reads and captures the answers.
`timescale 1ns/1ns
module mgmt_host
  import partner_ability_pkg::*;
(
  input  wire logic        clk,
  output rd_req_type       rd_req,
  input  wire logic [31:0] rd_data_q,
  input  wire logic        rd_valid_q
);
  logic [31:0] got;

  initial begin
    rd_req <= '0;
    got    = 32'h0000_0000;
  end

  // One-cycle read request; the answer must be valid exactly one cycle later.
  task automatic rd(input logic ser, input logic [11:0] a);
    @(posedge clk);
    rd_req <= '{en: 1'b1, serial: ser, addr: a};
    @(posedge clk);
    rd_req <= '0;
    @(posedge clk);
    got = rd_valid_q ? rd_data_q : 32'hxxxx_xxxx;
  endtask
endmodule // mgmt_host

/* dv/tb_partner_ability.sv */
// Self-checking bench for the emulated partner ability word.
`timescale 1ns/1ns
module tb_partner_ability
  import partner_ability_pkg::*;
;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  wr_req_type  wr_req  = '0;
  rd_req_type  rd_req;
  logic [15:0] adv     = 16'h0000;
  logic        an_fail = 1'b0;
  logic        dup     = 1'b0;
  logic        spd     = 1'b0;
  logic        pol     = 1'b0;
  logic        miss;
  logic        rd_valid_q;
  logic [31:0] rd_data_q;
  logic [31:0] exp_w;
  logic [31:0] exp_q[$];
  logic [31:0] rnd;
  logic [31:0] seed    = 32'h0000_0001;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cycles      = 0;

  always #25 clk = ~clk;

  partner_ability dut (.clk(clk), .rst(rst), .rd_req(rd_req), .wr_req(wr_req),
    .vphy_advert_reg(adv), .an_fail(an_fail), .duplex_pin(dup), .speed_strap_pin(spd),
    .duplex_pol_strap_pin(pol), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

  mgmt_host host (.clk(clk), .rd_req(rd_req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected word from the present inputs and the straps held since reset.
  function automatic logic [31:0] model(input logic sp, input logic pl);
    int w;
    w = 32'h0000_4001;
    case ({adv[11], adv[10]})
      2'b01: w += 32'h0000_0400;
      2'b10: w += 32'h0000_0c00;
      2'b11: w += 32'h0000_0800;
      default: ;
    endcase
    if (!an_fail) begin
      w += (dup == pl) ? (sp ? 32'h0000_0100 : 32'h0000_0040)
                       : (sp ? 32'h0000_0080 : 32'h0000_0020);
    end
    return w;
  endfunction

  task automatic check(input logic [31:0] e);
    num_checks++;
    if (host.got !== e) begin
      miscompares++;
      $display("mismatch rd_data_q expected %h seen %h", e, host.got);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int s = 0; s < 4; s++) begin
      spd <= s[0];
      pol <= s[1];
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      spd <= ~s[0];
      pol <= ~s[1];
      for (int i = 0; i < 24; i++) begin
        rnd = xs();
        adv <= rnd[15:0];
        dup <= rnd[16];
        an_fail <= (rnd[19:17] == 3'h0);
        wr_req <= '{en: rnd[20], serial: rnd[21], addr: 12'h01d4, data: xs()};
        repeat (3) @(posedge clk);
        miss = (rnd[23:22] == 2'h0);
        exp_w = miss ? 32'h0000_0000 : model(s[0], s[1]);
        exp_q.push_back(exp_w);
        host.rd(rnd[21], (rnd[21] ? 12'h0005 : 12'h01d4) + (miss ? 12'h0004 : 12'h0000));
        check(exp_q.pop_front());
      end
    end
    final_report();
  end
endmodule // tb_partner_ability
